// [pkg/timer_compare_params.svh]
// Register map, field positions and reset values of the compare unit
`ifndef TIMER_COMPARE_PARAMS_SVH
`define TIMER_COMPARE_PARAMS_SVH
`define OFS_CTRL1 8'h00
`define OFS_CTRL2 8'h04
`define OFS_STATUS 8'h08
`define OFS_CMP1_HI 8'h0C
`define OFS_CMP1_LO 8'h10
`define OFS_CMP2_HI 8'h14
`define OFS_CMP2_LO 8'h18
`define OFS_CNT_HI 8'h1C
`define OFS_CNT_LO 8'h20
`define OFS_CAP1_HI 8'h24
`define OFS_CAP1_LO 8'h28
`define OFS_CAP2_HI 8'h2C
`define OFS_CAP2_LO 8'h30
`define C1_CAP_IRQ_EN 7
`define C1_CMP_IRQ_EN 6
`define C1_FORCE2 4
`define C1_FORCE1 3
`define C1_LEVEL2 2
`define C1_EDGE1 1
`define C1_LEVEL1 0
`define C2_PIN1_EN 7
`define C2_PIN2_EN 6
`define C2_ONE_PULSE 5
`define C2_PWM 4
`define C2_CLK_HI 3
`define C2_CLK_LO 2
`define C2_EDGE2 1
`define C2_EXT_EDGE 0
`define ST_CAP1 7
`define ST_CMP1 6
`define ST_CAP2 4
`define ST_CMP2 3
`define CTRL_RESET 8'h00
`define CMP_RESET 16'h8000
`define CNT_RELOAD 16'hFFFC
`define CAP_PULSE_VALUE 16'hFFFD
`endif

// [pkg/timer_compare_pkg.sv]
// Types shared by the compare unit and its users
package timer_compare_pkg;
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b001,
        MODE_ONE_PULSE = 3'b010,
        MODE_PWM = 3'b100
    } timer_mode_t;
    typedef struct packed {
        logic [1:0] level;
        logic [1:0] select;
    } pin_out_t;
endpackage : timer_compare_pkg

// [verilog/timer_compare_pulse_unit.sv]
// Output compare, one pulse and PWM unit with its AHB-Lite register slave
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`include "timer_compare_params.svh"
module timer_compare_pulse_unit
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic trigger_input_one,
    input wire logic capture_input_two,
    input wire logic ext_timer_clock,
    input wire logic irq_mask,
    output timer_compare_pkg::pin_out_t compare_output_pin,
    output logic timer_irq
);
    import timer_compare_pkg::*;

    // Bus slave: one wait state per transfer, so writes land before reads
    logic pend;
    logic pend_write;
    logic pend_mapped;
    logic [7:0] pend_addr;
    wire take = hsel & htrans[1] & hready;
    wire addr_mapped = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'b00);
    assign hreadyout = ~pend;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend <= 1'b0;
            pend_write <= 1'b0;
            pend_mapped <= 1'b0;
            pend_addr <= 8'h00;
        end
        else
        begin
            pend <= take;
            if (take)
            begin
                pend_write <= hwrite;
                pend_mapped <= addr_mapped;
                pend_addr <= haddr[7:0];
            end
        end
    end

    wire acc = pend & pend_mapped;
    wire wr = acc & pend_write;
    wire rd = acc & ~pend_write;
    wire [7:0] wbyte = hwdata[7:0];
    wire wr_ctrl1 = wr & (pend_addr == `OFS_CTRL1);
    wire wr_ctrl2 = wr & (pend_addr == `OFS_CTRL2);
    wire rd_status = rd & (pend_addr == `OFS_STATUS);
    wire wr_c1_hi = wr & (pend_addr == `OFS_CMP1_HI);
    wire wr_c1_lo = wr & (pend_addr == `OFS_CMP1_LO);
    wire wr_c2_hi = wr & (pend_addr == `OFS_CMP2_HI);
    wire wr_c2_lo = wr & (pend_addr == `OFS_CMP2_LO);
    wire acc_c1_lo = acc & (pend_addr == `OFS_CMP1_LO);
    wire acc_c2_lo = acc & (pend_addr == `OFS_CMP2_LO);
    wire acc_cap1_lo = acc & (pend_addr == `OFS_CAP1_LO);
    wire acc_cap2_lo = acc & (pend_addr == `OFS_CAP2_LO);
    wire wr_cnt_lo = wr & (pend_addr == `OFS_CNT_LO);

    // Control registers; forced-output bits act on write in normal mode only and are not stored
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl1 <= `CTRL_RESET;
            ctrl2 <= `CTRL_RESET;
        end
        else
        begin
            if (wr_ctrl1)
                ctrl1 <= wbyte & 8'hE7;
            if (wr_ctrl2)
                ctrl2 <= wbyte;
        end
    end

    wire level1 = ctrl1[`C1_LEVEL1];
    wire level2 = ctrl1[`C1_LEVEL2];
    wire pin1_en = ctrl2[`C2_PIN1_EN];
    wire pin2_en = ctrl2[`C2_PIN2_EN];
    wire [1:0] clk_sel = ctrl2[`C2_CLK_HI:`C2_CLK_LO];
    timer_mode_t mode;
    assign mode = ctrl2[`C2_PWM] ? MODE_PWM :
        (ctrl2[`C2_ONE_PULSE] ? MODE_ONE_PULSE : MODE_NORMAL);
    wire m_norm = (mode == MODE_NORMAL);
    wire m_opm = (mode == MODE_ONE_PULSE);
    wire m_pwm = (mode == MODE_PWM);
    wire [1:0] force_out = {wr_ctrl1 & wbyte[`C1_FORCE2],
        wr_ctrl1 & wbyte[`C1_FORCE1]} & {2{m_norm}};

    // Timer tick from the hclk prescaler or the external clock edge
    logic [2:0] presc;
    logic ext_prev;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            presc <= 3'h0;
            ext_prev <= 1'b0;
        end
        else
        begin
            presc <= presc + 3'h1;
            ext_prev <= ext_timer_clock;
        end
    end
    wire ext_edge = ctrl2[`C2_EXT_EDGE] ? (ext_timer_clock & ~ext_prev) :
        (~ext_timer_clock & ext_prev);
    wire [2:0] presc_mask = (clk_sel == 2'b01) ? 3'h1 :
        ((clk_sel == 2'b00) ? 3'h3 : 3'h7);
    wire tick = (clk_sel == 2'b11) ? ext_edge :
        ((presc & presc_mask) == presc_mask);

    // Compare registers: software copy and the copy the comparators see
    logic [15:0] cmp [2];
    logic [15:0] cmp_act [2];
    logic [1:0] inhibit;
    logic [15:0] cnt;
    wire [1:0] match;
    wire [1:0] hi_wr = {wr_c2_hi, wr_c1_hi};
    wire [1:0] lo_wr = {wr_c2_lo, wr_c1_lo};
    wire period_end = m_pwm & match[1];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_cmp
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    cmp[gi] <= `CMP_RESET;
                    cmp_act[gi] <= `CMP_RESET;
                    inhibit[gi] <= 1'b0;
                end
                else
                begin
                    if (hi_wr[gi])
                        cmp[gi][15:8] <= wbyte;
                    if (lo_wr[gi])
                        cmp[gi][7:0] <= wbyte;
                    if (!m_pwm || period_end)
                        cmp_act[gi] <= cmp[gi];
                    if (hi_wr[gi])
                        inhibit[gi] <= 1'b1;
                    else if (lo_wr[gi])
                        inhibit[gi] <= 1'b0;
                end
            end
            assign match[gi] = tick & ~inhibit[gi] &
                (cnt == cmp_act[gi]);
        end
    endgenerate

    // Edge detection on the capture inputs
    logic trig_prev;
    logic cap2_prev;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trig_prev <= 1'b0;
            cap2_prev <= 1'b0;
        end
        else
        begin
            trig_prev <= trigger_input_one;
            cap2_prev <= capture_input_two;
        end
    end
    wire edge1 = ctrl1[`C1_EDGE1] ? (trigger_input_one & ~trig_prev) :
        (~trigger_input_one & trig_prev);
    wire edge2 = ctrl2[`C2_EDGE2] ? (capture_input_two & ~cap2_prev) :
        (~capture_input_two & cap2_prev);
    wire opm_trig = m_opm & edge1;

    // Free-running counter; FFFCh is the only value ever loaded
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt <= `CNT_RELOAD;
        else if (opm_trig || period_end || wr_cnt_lo)
            cnt <= `CNT_RELOAD;
        else if (tick)
            cnt <= cnt + 16'h0001;
    end

    // Capture registers
    logic [15:0] cap1;
    logic [15:0] cap2;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cap1 <= 16'h0000;
            cap2 <= 16'h0000;
        end
        else
        begin
            if (opm_trig)
                cap1 <= `CAP_PULSE_VALUE;
            else if (m_norm && edge1)
                cap1 <= cnt;
            if (edge2)
                cap2 <= cnt;
        end
    end

    // Status flags: set wins over the two-step clear
    logic [3:0] flag;
    logic [3:0] armed;
    wire [3:0] flag_set = {
        edge2,                                      // capture two
        m_norm & match[0],
        ~m_pwm & match[1],
        (m_norm & edge1) | opm_trig | period_end};
    wire [3:0] clr_acc = {acc_cap2_lo, acc_c1_lo, acc_c2_lo, acc_cap1_lo};
    wire [3:0] flag_clr = clr_acc & armed;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            flag <= 4'h0;
            armed <= 4'h0;
        end
        else
        begin
            flag <= flag_set | (flag & ~flag_clr);
            if (rd_status)
                armed <= flag;
            else
                armed <= armed & ~clr_acc;
        end
    end
    wire cap1_f = flag[0];
    wire cmp2_f = flag[1];
    wire cmp1_f = flag[2];
    wire cap2_f = flag[3];

    assign timer_irq = ~irq_mask &
        ((ctrl1[`C1_CMP_IRQ_EN] & (cmp1_f | cmp2_f)) |
        (ctrl1[`C1_CAP_IRQ_EN] & (cap1_f | cap2_f)));

    // Output pin latches
    logic [1:0] pin;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pin <= 2'b00;
        else
        begin
            if (pin1_en)
            begin
                if (opm_trig || period_end)
                    pin[0] <= level2;
                else if (match[0] && !m_norm)
                    pin[0] <= level1;
                else if (m_norm && match[0])
                    pin[0] <= level1;
                // Forcing copies the level written in the same access
                else if (force_out[0])
                    pin[0] <= wbyte[`C1_LEVEL1];
            end
            if (pin2_en && m_norm && match[1])
                pin[1] <= level2;
            else if (pin2_en && force_out[1])
                pin[1] <= wbyte[`C1_LEVEL2];
        end
    end
    assign compare_output_pin.level = pin;
    assign compare_output_pin.select = {pin2_en & m_norm, pin1_en};

    // Read data
    wire [7:0] status_byte = {cap1_f, cmp1_f, 1'b0, cap2_f, cmp2_f, 3'b000};
    logic [7:0] rmux;
    always_comb
    begin
        unique case (pend_addr)
            `OFS_CTRL1: rmux = ctrl1;
            `OFS_CTRL2: rmux = ctrl2;
            `OFS_STATUS: rmux = status_byte;
            `OFS_CMP1_HI: rmux = cmp[0][15:8];
            `OFS_CMP1_LO: rmux = cmp[0][7:0];
            `OFS_CMP2_HI: rmux = cmp[1][15:8];
            `OFS_CMP2_LO: rmux = cmp[1][7:0];
            `OFS_CNT_HI: rmux = cnt[15:8];
            `OFS_CNT_LO: rmux = cnt[7:0];
            `OFS_CAP1_HI: rmux = cap1[15:8];
            `OFS_CAP1_LO: rmux = cap1[7:0];
            `OFS_CAP2_HI: rmux = cap2[15:8];
            `OFS_CAP2_LO: rmux = cap2[7:0];
            default: rmux = 8'h00;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (pend)
            hrdata <= {24'h000000, rd ? rmux : 8'h00};
    end

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_flag_on_match;
        m_norm && match[0] |=> cmp1_f;
    endproperty
    a_flag_on_match: assert property (p_flag_on_match)
        else $error("compare flag one not set on match");
    property p_pin_takes_level;
        m_norm && match[0] && pin1_en && !opm_trig |=> pin[0] == $past(level1);
    endproperty
    a_pin_takes_level: assert property (p_pin_takes_level)
        else $error("pin one did not take its level");
    property p_irq_gate;
        timer_irq |-> !irq_mask &&
            (ctrl1[`C1_CMP_IRQ_EN] || ctrl1[`C1_CAP_IRQ_EN]);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised while masked or disabled");
    property p_hi_write_inhibits;
        wr_c1_hi ##1 !wr_c1_lo |=> !match[0];
    endproperty
    a_hi_write_inhibits: assert property (p_hi_write_inhibits)
        else $error("compare ran after high byte write");
    property p_clear_needs_arm;
        cmp1_f && !armed[2] && !rd_status |=> cmp1_f;
    endproperty
    a_clear_needs_arm: assert property (p_clear_needs_arm)
        else $error("flag cleared without status read");
    property p_opm_trigger;
        opm_trig |=> cnt == `CNT_RELOAD && cap1 == `CAP_PULSE_VALUE && cap1_f;
    endproperty
    a_opm_trigger: assert property (p_opm_trigger)
        else $error("pulse trigger did not reload and capture");
    property p_pwm_reload;
        period_end |=> cnt == `CNT_RELOAD && cap1_f && !$rose(cmp2_f);
    endproperty
    a_pwm_reload: assert property (p_pwm_reload)
        else $error("period end did not reload counter");
    property p_no_flag_one_opm;
        m_opm && !cmp1_f ##1 m_opm |-> !cmp1_f;
    endproperty
    a_no_flag_one_opm: assert property (p_no_flag_one_opm)
        else $error("compare flag one set in one pulse mode");
    property p_force_no_flag;
        force_out[0] && !match[0] && !cmp1_f |=> !cmp1_f;
    endproperty
    a_force_no_flag: assert property (p_force_no_flag)
        else $error("forced output set the compare flag");
    property p_pin_disabled;
        !pin1_en |=> pin[0] == $past(pin[0]);
    endproperty
    a_pin_disabled: assert property (p_pin_disabled)
        else $error("disabled pin changed");
    property p_pwm_hold;
        m_pwm && !period_end |=> cmp_act[0] == $past(cmp_act[0]);
    endproperty
    a_pwm_hold: assert property (p_pwm_hold)
        else $error("pulse compare value changed inside a period");
    property p_one_wait;
        take |=> !hreadyout ##1 hreadyout;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("bus answer not after one wait state");

    c_normal_match: cover property (m_norm && match[0] && pin1_en);
    c_opm_pulse: cover property (opm_trig ##[1:1000] match[0]);
    c_pwm_period: cover property (period_end ##[1:1000] period_end);
    c_flag_clear: cover property (rd_status ##[1:20] flag_clr[2]);
endmodule : timer_compare_pulse_unit

// [tb/pin_partner.sv]
// Model of the pins around the compare unit: trigger and clock sources
`timescale 1ns/100ps
module pin_partner
(
    input wire logic hclk,
    input wire logic fire,
    output logic trig = 1'b0,
    output logic cap2 = 1'b0,
    output logic ext_clk = 1'b0
);
    logic [3:0] hold = 4'h0;
    logic [2:0] div = 3'h0;

    // Trigger is one clean rising edge held long enough to be sampled
    always @(posedge hclk)
    begin
        div <= div + 3'h1;
        ext_clk <= div[2];
        if (fire)
            hold <= 4'h8;
        else if (hold != 4'h0)
            hold <= hold - 4'h1;
        trig <= fire || hold != 4'h0;
        cap2 <= fire || hold != 4'h0;
    end
endmodule : pin_partner

// [tb/tb_top.sv]
// Self-checking bench for the compare, one pulse and PWM unit
`timescale 1ns/100ps
`include "timer_compare_params.svh"
module tb_top;
    import timer_compare_pkg::*;
    typedef struct {string n; logic [31:0] v;} note_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic irq_mask = 1'b1;
    logic fire = 1'b0;
    logic trig;
    logic cap2;
    logic ext_clk;
    logic timer_irq;
    pin_out_t pins;
    note_t exp_q[$];
    logic [31:0] seen;
    logic [31:0] r;
    logic [7:0] v;
    logic last;
    event seen_ev;
    int fail_count = 0;
    int check_count = 0;
    int seed = 32'hcba237d4;
    int n;
    int rises;

    initial
    begin
        forever #10 hclk = ~hclk;
    end

    timer_compare_pulse_unit uut
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .trigger_input_one(trig),
        .capture_input_two(cap2),
        .ext_timer_clock(ext_clk),
        .irq_mask(irq_mask),
        .compare_output_pin(pins),
        .timer_irq(timer_irq)
    );

    pin_partner far_pins
    (
        .hclk(hclk),
        .fire(fire),
        .trig(trig),
        .cap2(cap2),
        .ext_clk(ext_clk)
    );

    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string nm, input logic [31:0] e,
        input logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    // Watches read results and pairs each with the oldest note
    initial
    begin
        forever
        begin
            @(seen_ev);
            if (exp_q.size() != 0)
            begin
                check(exp_q[0].n, exp_q[0].v, seen);
                void'(exp_q.pop_front());
            end
        end
    end

    // hreadyout is stable at the falling edge, so that value is the one
    // the next rising edge samples
    task automatic wait_ready();
        int k = 0;
        do
        begin
            @(negedge hclk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            $display("ERROR bus wait timed out");
            fail_count++;
            tally_and_finish();
        end
    endtask : wait_ready

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready();
        @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_ready();
        q = hrdata;
        @(posedge hclk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rd_exp(input string nm, input logic [7:0] a,
        input logic [7:0] e);
        exp_q.push_back('{nm, {24'h0, e}});
        bus(1'b0, a, 8'h00, seen);
        ->seen_ev;
    endtask : rd_exp

    task automatic wait_status(input logic [7:0] mask);
        int k = 0;
        do
        begin
            bus(1'b0, `OFS_STATUS, 8'h00, r);
            k++;
        end
        while ((r[7:0] & mask) == 8'h00 && k < 300);
        if (k >= 300)
        begin
            $display("ERROR status wait timed out");
            fail_count++;
            tally_and_finish();
        end
        check("status flag", 1'b1, |(r[7:0] & mask));
    endtask : wait_status

    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        irq_mask <= 1'b1;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset

    initial
    begin
        do_reset();
        rd_exp("cmp1_hi", `OFS_CMP1_HI, 8'h80);
        rd_exp("cmp1_lo", `OFS_CMP1_LO, 8'h00);
        rd_exp("cmp2_hi", `OFS_CMP2_HI, 8'h80);
        rd_exp("unmapped", 8'h40, 8'h00);
        check("pins", pins.level, 2'b00);
        check("hresp", hresp, 1'b0);
        wr(`OFS_CMP2_HI, 8'h5A);
        rd_exp("cmp2_hi", `OFS_CMP2_HI, 8'h5A);
        $display("Test reset values done");

        do_reset();
        v = 8'h08 + {5'h0, 3'($random(seed))};
        irq_mask <= 1'b0;
        wr(`OFS_CTRL1, 8'h45);
        wr(`OFS_CTRL2, 8'h80);
        check("select", pins.select, 2'b01);
        wr(`OFS_CMP1_HI, 8'h00);
        wr(`OFS_CMP1_LO, v);
        wr(`OFS_CMP2_HI, 8'h00);
        wr(`OFS_CMP2_LO, 8'h30);
        wr(`OFS_CNT_LO, 8'h00);
        wait_status(8'h40);
        check("pin1", pins.level[0], 1'b1);
        check("irq", timer_irq, 1'b1);
        irq_mask <= 1'b1;
        @(negedge hclk);
        check("irq masked", timer_irq, 1'b0);
        wait_status(8'h08);
        check("pin2", pins.level[1], 1'b0);
        rd_exp("cmp1_lo", `OFS_CMP1_LO, v);
        rd_exp("status", `OFS_STATUS, 8'h08);
        $display("Test normal compare done");

        do_reset();
        wr(`OFS_CTRL2, 8'h80);
        wr(`OFS_CTRL1, 8'h01);
        wr(`OFS_CMP1_HI, 8'h00);
        wr(`OFS_CNT_LO, 8'h00);
        repeat (80) @(posedge hclk);
        rd_exp("status", `OFS_STATUS, 8'h00);
        check("pin1", pins.level[0], 1'b0);
        wr(`OFS_CMP1_LO, 8'h06);
        wr(`OFS_CNT_LO, 8'h00);
        wait_status(8'h40);
        $display("Test compare inhibit done");

        do_reset();
        wr(`OFS_CTRL2, 8'h80);
        wr(`OFS_CTRL1, 8'h09);
        @(negedge hclk);
        check("pin1", pins.level[0], 1'b1);
        rd_exp("status", `OFS_STATUS, 8'h00);
        rd_exp("ctrl1", `OFS_CTRL1, 8'h01);
        wr(`OFS_CTRL2, 8'hA0);
        wr(`OFS_CTRL1, 8'h08);
        @(negedge hclk);
        check("pin1", pins.level[0], 1'b1);
        $display("Test forced output done");

        do_reset();
        irq_mask <= 1'b0;
        wr(`OFS_CMP1_HI, 8'h00);
        wr(`OFS_CMP1_LO, 8'h20);
        wr(`OFS_CTRL1, 8'h86);
        wr(`OFS_CTRL2, 8'hA2);
        @(posedge hclk);
        fire <= 1'b1;
        @(posedge hclk);
        fire <= 1'b0;
        repeat (6) @(negedge hclk);
        check("pin1", pins.level[0], 1'b1);
        check("irq", timer_irq, 1'b1);
        rd_exp("status", `OFS_STATUS, 8'h90);
        rd_exp("cap1_hi", `OFS_CAP1_HI, 8'hFF);
        rd_exp("cap1_lo", `OFS_CAP1_LO, 8'hFD);
        n = 0;
        while (pins.level[0] === 1'b1 && n < 300)
        begin
            @(negedge hclk);
            n++;
        end
        check("pulse end", pins.level[0], 1'b0);
        check("pulse long", 1'b1, n > 100);
        rd_exp("status", `OFS_STATUS, 8'h10);
        $display("Test one pulse done");

        do_reset();
        wr(`OFS_CMP1_HI, 8'h00);
        wr(`OFS_CMP1_LO, 8'h04);
        wr(`OFS_CMP2_HI, 8'h00);
        wr(`OFS_CMP2_LO, 8'h0C);
        wr(`OFS_CTRL1, 8'h04);
        wr(`OFS_CTRL2, 8'hB0);
        wr(`OFS_CNT_LO, 8'h00);
        wait_status(8'h80);
        wr(`OFS_CMP1_LO, 8'h06);
        rises = 0;
        last = pins.level[0];
        for (n = 0; n < 200; n++)
        begin
            @(negedge hclk);
            if (pins.level[0] === 1'b1 && last === 1'b0)
                rises++;
            last = pins.level[0];
        end
        check("pwm rises", 1'b1, rises >= 2);
        rd_exp("status", `OFS_STATUS, 8'h80);
        $display("Test pwm done");
        tally_and_finish();
    end
endmodule : tb_top
